// ==== core/lcdrce_pkg.sv ====
package lcdrce_pkg;
  localparam logic [7:0] CMD_CTRL       = 8'h40;
  localparam logic [7:0] CMD_CTRL_MASK  = 8'hfc;
  localparam logic [7:0] CMD_ADP        = 8'h24;
  localparam logic [7:0] CMD_NIB_MASK   = 8'hf0;
  localparam logic [7:0] CMD_MODE       = 8'h80;
  localparam logic [7:0] CMD_DISP       = 8'h90;
  localparam logic [7:0] CMD_OCT_MASK   = 8'hf8;
  localparam logic [7:0] CMD_CUR        = 8'ha0;
  localparam logic [7:0] CMD_AUTO_WR    = 8'hb0;
  localparam logic [7:0] CMD_AUTO_RD    = 8'hb1;
  localparam logic [7:0] CMD_AUTO_RST   = 8'hb2;
  localparam logic [7:0] CMD_DRW        = 8'hc0;
  localparam logic [2:0] DRW_LAST       = 3'h5;
  localparam logic [1:0] DRW_INC        = 2'h0;
  localparam logic [1:0] DRW_DEC        = 2'h1;
  localparam logic [7:0] CMD_PEEK       = 8'he0;
  localparam logic [7:0] CMD_COPY       = 8'he8;
  localparam logic [2:0] MODE_OR        = 3'h0;
  localparam logic [2:0] MODE_EXOR      = 3'h1;
  localparam logic [2:0] MODE_AND       = 3'h3;
  localparam logic [2:0] MODE_ATTR      = 3'h4;
  localparam int         MODE_CG_BIT    = 3;
  localparam int         DISP_GFX_BIT   = 3;
  localparam int         DISP_TXT_BIT   = 2;
  localparam int         DISP_CUR_BIT   = 1;
  localparam int         DISP_BLINK_BIT = 0;
  localparam int         ST_CMD_OK      = 0;
  localparam int         ST_DATA_OK     = 1;
  localparam int         ST_AUTO_RD     = 2;
  localparam int         ST_AUTO_WR     = 3;
  localparam int         ST_PEEK_ERR    = 6;
  localparam logic [7:0] CG_INT_LAST    = 8'h7f;
  localparam logic [2:0] ATTR_NORMAL    = 3'h0;
  localparam logic [2:0] ATTR_REVERSE   = 3'h5;
  localparam logic [2:0] ATTR_INHIBIT   = 3'h3;
  localparam int         ATTR_BLINK_BIT = 3;
  localparam logic [6:0] COLS_HH        = 7'h20;
  localparam logic [6:0] COL_ONE        = 7'h01;
  localparam logic [15:0] ADP_STEP      = 16'h0001;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [3:0] CUR_LINES_RST  = 4'h1;
  localparam logic [3:0] CUR_ONE        = 4'h1;
  localparam logic [1:0] CTRL_TXT_AREA  = 2'h1;
  localparam logic [1:0] CTRL_GFX_HOME  = 2'h2;
  localparam logic [1:0] CTRL_GFX_AREA  = 2'h3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       cd;
    logic [7:0] data;
  } lcdrce_host_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } lcdrce_mem_type;

  typedef struct packed {
    logic blink;
    logic reverse;
    logic inhibit;
  } lcdrce_attr_type;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RD_A    = 2'b01,
    ST_RD_B    = 2'b10,
    ST_COPY_WR = 2'b11
  } lcdrce_state_type;

  typedef enum logic [1:0] {
    OP_DATA = 2'b00,
    OP_PEEK = 2'b01,
    OP_COPY = 2'b10
  } lcdrce_op_type;
endpackage

// ==== core/lcdrce_engine.sv ====
`timescale 1ns/1ps
module lcdrce_engine
  import lcdrce_pkg::*;
#(
  parameter logic [6:0]  COLS_HL  = 7'h28,
  parameter logic [6:0]  COLS_LH  = 7'h28,
  parameter logic [6:0]  COLS_LL  = 7'h28,
  parameter logic [15:0] LCD_ROWS = 16'h0040
) (
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire lcdrce_host_type host_i,
  output logic [7:0]           host_data_o,
  input  wire logic            column_cfg_pin_a_i,
  input  wire logic            column_cfg_pin_b_i,
  input  wire logic [7:0]      mem_rdata_i,
  output lcdrce_mem_type       mem_o,
  input  wire logic [7:0]      text_pix_i,
  input  wire logic            scan_frame_i,
  input  wire logic            scan_row_i,
  input  wire logic            scan_txt_row_i,
  input  wire logic            scan_col_i,
  output logic [15:0]          scan_txt_addr_o,
  output logic [15:0]          scan_gfx_addr_o,
  output logic [6:0]           hw_column_count_o,
  output logic                 txt_en_o,
  output logic                 gfx_en_o,
  output logic                 attr_fetch_o,
  output logic                 cursor_en_o,
  output logic                 cursor_blink_o,
  output logic [3:0]           cursor_lines_o,
  input  wire logic [7:0]      attr_byte_i,
  output lcdrce_attr_type      attr_o,
  input  wire logic [7:0]      cg_code_i,
  output logic                 cg_ext_o,
  output logic                 peek_error_flag_o
);

  lcdrce_state_type state_q;
  lcdrce_op_type    op_q;
  logic [15:0]      ctrl_q [4];
  logic [15:0]      prm_q;
  logic [15:0]      adp_q;
  logic [3:0]       mode_q;
  logic [3:0]       disp_q;
  logic [3:0]       cur_lines_q;
  logic [7:0]       stack_q;
  logic [6:0]       col_q;
  logic [6:0]       scan_col_q;
  logic [6:0]       hw_cols_d;
  logic [6:0]       hw_cols_q;
  logic             auto_wr_q;
  logic             auto_rd_q;
  logic             peek_err_q;
  logic [7:0]       cmd;
  logic             idle;
  logic             cmd_wr;
  logic             dat_wr;
  logic             dat_rd;
  logic             accept;
  logic             is_ctrl;
  logic             is_drw;
  logic             is_peek;
  logic             is_copy;
  logic             is_arst;
  logic             peek_ok;
  logic             scan_last;
  logic [7:0]       status;

  function automatic logic [7:0] combine(input logic [7:0] g, input logic [7:0] t,
                                         input logic [3:0] md, input logic [3:0] ds);
    logic [7:0] ge;
    logic [7:0] te;
    ge = ds[DISP_GFX_BIT] ? g : 8'h00;
    te = ds[DISP_TXT_BIT] ? t : 8'h00;
    if (md[2:0] == MODE_EXOR) begin
      combine = ge ^ te;
    end else if (md[2:0] == MODE_AND) begin
      combine = ge & te;
    end else begin
      combine = ge | te;
    end
  endfunction

  function automatic logic in_gfx(input logic [15:0] a, input logic [15:0] home,
                                  input logic [15:0] area);
    logic [31:0] len;
    logic [15:0] off;
    len = area * LCD_ROWS;
    off = a - home;
    in_gfx = (a >= home) && (off < len[15:0]);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // host decode
  assign cmd     = host_i.data;
  assign idle    = (state_q == ST_IDLE);
  assign cmd_wr  = host_i.wr & host_i.cd & idle;
  assign dat_wr  = host_i.wr & ~host_i.cd & idle;
  assign dat_rd  = host_i.rd & ~host_i.cd & idle;
  assign is_arst = (cmd == CMD_AUTO_RST);
  assign accept  = cmd_wr & (~(auto_wr_q | auto_rd_q) | is_arst);
  assign is_ctrl = ((cmd & CMD_CTRL_MASK) == CMD_CTRL);
  assign is_drw  = ((cmd & CMD_OCT_MASK) == CMD_DRW) && (cmd[2:0] <= DRW_LAST);
  assign is_peek = (cmd == CMD_PEEK);
  assign is_copy = (cmd == CMD_COPY);
  assign peek_ok = in_gfx(adp_q, ctrl_q[CTRL_GFX_HOME], ctrl_q[CTRL_GFX_AREA]);

  // parameters arrive before their command, low byte first
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prm_q <= ZERO16;
    end else if (dat_wr && !auto_wr_q) begin
      prm_q <= {cmd, prm_q[15:8]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 4; i++) begin
        ctrl_q[i] <= ZERO16;
      end
    end else if (accept && is_ctrl) begin
      ctrl_q[cmd[1:0]] <= prm_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_q      <= 4'h0;
      disp_q      <= 4'h0;
      cur_lines_q <= CUR_LINES_RST;
    end else if (accept) begin
      if ((cmd & CMD_NIB_MASK) == CMD_MODE) begin
        mode_q <= cmd[3:0];
      end
      if ((cmd & CMD_NIB_MASK) == CMD_DISP) begin
        disp_q <= cmd[3:0];
      end
      if ((cmd & CMD_OCT_MASK) == CMD_CUR) begin
        cur_lines_q <= 4'(cmd[2:0]) + CUR_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      auto_wr_q <= 1'b0;
      auto_rd_q <= 1'b0;
    end else if (accept) begin
      if (cmd == CMD_AUTO_WR) begin
        auto_wr_q <= 1'b1;
      end else if (cmd == CMD_AUTO_RD) begin
        auto_rd_q <= 1'b1;
      end else if (is_arst) begin
        auto_wr_q <= 1'b0;
        auto_rd_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address pointer
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      adp_q <= ZERO16;
    end else if (accept && cmd == CMD_ADP) begin
      adp_q <= prm_q;
    end else if (accept && is_drw) begin
      if (cmd[2:1] == DRW_INC) begin
        adp_q <= adp_q + ADP_STEP;
      end else if (cmd[2:1] == DRW_DEC) begin
        adp_q <= adp_q - ADP_STEP;
      end
    end else if ((dat_wr && auto_wr_q) || (dat_rd && auto_rd_q) || (accept && cmd == CMD_AUTO_RD)) begin
      adp_q <= adp_q + ADP_STEP;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // memory sequencer; read data is valid one cycle after re
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      op_q    <= OP_DATA;
      mem_o   <= '0;
      stack_q <= 8'h00;
      col_q   <= 7'h00;
    end else begin
      mem_o.we <= 1'b0;
      mem_o.re <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (accept && is_drw) begin
            mem_o.addr <= adp_q;
            if (cmd[0]) begin
              mem_o.re <= 1'b1;
              op_q     <= OP_DATA;
              state_q  <= ST_RD_A;
            end else begin
              // the lone data byte is the newest one, so it sits in the upper half
              mem_o.we    <= 1'b1;
              mem_o.wdata <= prm_q[15:8];
            end
          end else if (accept && is_peek && peek_ok) begin
            mem_o.addr <= adp_q;
            mem_o.re   <= 1'b1;
            op_q       <= OP_PEEK;
            state_q    <= ST_RD_A;
          end else if (accept && is_copy) begin
            mem_o.addr <= adp_q;
            mem_o.re   <= 1'b1;
            col_q      <= 7'h00;
            op_q       <= OP_COPY;
            state_q    <= ST_RD_A;
          end else if (dat_wr && auto_wr_q) begin
            mem_o.addr  <= adp_q;
            mem_o.wdata <= cmd;
            mem_o.we    <= 1'b1;
          end else if ((dat_rd && auto_rd_q) || (accept && cmd == CMD_AUTO_RD)) begin
            mem_o.addr <= adp_q;
            mem_o.re   <= 1'b1;
            op_q       <= OP_DATA;
            state_q    <= ST_RD_A;
          end
        end
        ST_RD_A: begin
          state_q <= ST_RD_B;
        end
        ST_RD_B: begin
          if (op_q == OP_COPY) begin
            mem_o.wdata <= combine(mem_rdata_i, text_pix_i, mode_q, disp_q);
            mem_o.we    <= 1'b1;
            state_q     <= ST_COPY_WR;
          end else begin
            // peek result stands in the stack until the next fetch
            stack_q <= (op_q == OP_PEEK) ? combine(mem_rdata_i, text_pix_i, mode_q, disp_q)
                                         : mem_rdata_i;
            state_q <= ST_IDLE;
          end
        end
        ST_COPY_WR: begin
          if (col_q == hw_cols_q - COL_ONE) begin
            state_q <= ST_IDLE;
          end else begin
            col_q      <= col_q + COL_ONE;
            mem_o.addr <= adp_q + 16'(col_q + COL_ONE);
            mem_o.re   <= 1'b1;
            state_q    <= ST_RD_A;
          end
        end
      endcase
    end
  end

  // set wins over the clear by the same command; any later accepted command clears it
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      peek_err_q <= 1'b0;
    end else if (accept && is_peek && !peek_ok) begin
      peek_err_q <= 1'b1;
    end else if (accept) begin
      peek_err_q <= 1'b0;
    end
  end

  always_comb begin
    status              = 8'h00;
    status[ST_CMD_OK]   = idle & ~(auto_wr_q | auto_rd_q);
    status[ST_DATA_OK]  = idle & ~(auto_wr_q | auto_rd_q);
    status[ST_AUTO_RD]  = idle & auto_rd_q;
    status[ST_AUTO_WR]  = idle & auto_wr_q;
    status[ST_PEEK_ERR] = peek_err_q;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      host_data_o <= 8'h00;
    end else if (host_i.rd) begin
      host_data_o <= host_i.cd ? status : stack_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // display side
  always_comb begin
    unique case ({column_cfg_pin_a_i, column_cfg_pin_b_i})
      2'b11: hw_cols_d = COLS_HH;
      2'b10: hw_cols_d = COLS_HL;
      2'b01: hw_cols_d = COLS_LH;
      2'b00: hw_cols_d = COLS_LL;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hw_cols_q <= COLS_LL;
    end else begin
      hw_cols_q <= hw_cols_d;
    end
  end

  assign scan_last = (scan_col_q == hw_cols_q - COL_ONE);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      scan_col_q <= 7'h00;
    end else if (scan_frame_i || scan_row_i) begin
      scan_col_q <= 7'h00;
    end else if (scan_col_i) begin
      scan_col_q <= scan_last ? 7'h00 : scan_col_q + COL_ONE;
    end
  end

  // plane 0 text, plane 1 graphic
  for (genvar p = 0; p < 2; p++) begin : g_plane
    logic [15:0] base_q;
    logic [15:0] addr_q;
    logic        step_row;
    assign step_row = (p == 0) ? scan_txt_row_i : scan_row_i;
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        base_q <= ZERO16;
        addr_q <= ZERO16;
      end else if (scan_frame_i) begin
        base_q <= ctrl_q[2*p];
        addr_q <= ctrl_q[2*p];
      end else if (step_row) begin
        base_q <= base_q + ctrl_q[2*p+1];
        addr_q <= base_q + ctrl_q[2*p+1];
      end else if (scan_col_i) begin
        addr_q <= scan_last ? base_q : addr_q + ADP_STEP;
      end
    end
  end

  assign scan_txt_addr_o   = g_plane[0].addr_q;
  assign scan_gfx_addr_o   = g_plane[1].addr_q;
  assign hw_column_count_o = hw_cols_q;
  assign attr_fetch_o      = (mode_q[2:0] == MODE_ATTR);
  assign txt_en_o          = disp_q[DISP_TXT_BIT];
  assign gfx_en_o          = disp_q[DISP_GFX_BIT] & ~attr_fetch_o;
  assign cursor_en_o       = disp_q[DISP_CUR_BIT];
  assign cursor_blink_o    = disp_q[DISP_BLINK_BIT];
  assign cursor_lines_o    = cur_lines_q;
  assign peek_error_flag_o = peek_err_q;

  // upper attribute nibble ignored; unknown codes show normal
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      attr_o   <= '0;
      cg_ext_o <= 1'b0;
    end else begin
      attr_o.blink   <= attr_byte_i[ATTR_BLINK_BIT];
      attr_o.reverse <= (attr_byte_i[2:0] == ATTR_REVERSE);
      attr_o.inhibit <= (attr_byte_i[2:0] == ATTR_INHIBIT);
      cg_ext_o       <= mode_q[MODE_CG_BIT] | (cg_code_i > CG_INT_LAST);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  chk_auto_blocks: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (auto_wr_q || auto_rd_q) && cmd_wr && !is_arst |=> $stable(disp_q) && $stable(mode_q))
    else $error("command taken in auto mode");
  chk_auto_step: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    dat_wr && auto_wr_q |=> adp_q == $past(adp_q) + ADP_STEP && mem_o.we && mem_o.addr == $past(adp_q))
    else $error("auto write step wrong");
  chk_drw_dec: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    accept && is_drw && cmd[2:1] == DRW_DEC |=> adp_q == $past(adp_q) - ADP_STEP)
    else $error("pointer not decremented");
  chk_attr_gfx_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_q[2:0] == MODE_ATTR |-> !gfx_en_o && attr_fetch_o)
    else $error("graphic shown in attribute mode");
  chk_cols_pins: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    column_cfg_pin_a_i && column_cfg_pin_b_i |=> hw_column_count_o == COLS_HH)
    else $error("column count not 32");
  chk_peek_err: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    accept && is_peek && !peek_ok |=> peek_error_flag_o && state_q == ST_IDLE && !mem_o.re)
    else $error("bad peek not flagged");
  chk_copy_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    accept && is_copy |-> ##3 mem_o.we && mem_o.addr == $past(adp_q, 3))
    else $error("copy write missing");
  chk_gfx_stride: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    scan_row_i && !scan_frame_i |=> scan_gfx_addr_o == $past(g_plane[1].base_q) + $past(ctrl_q[CTRL_GFX_AREA]))
    else $error("graphic row stride wrong");
  chk_attr_rev: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    attr_byte_i[3:0] == {1'b0, ATTR_REVERSE} |=> attr_o.reverse && !attr_o.blink && !attr_o.inhibit)
    else $error("reverse attribute misdecoded");
  chk_area_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(accept && is_ctrl) |=> $stable(ctrl_q[CTRL_TXT_AREA]) && $stable(ctrl_q[CTRL_GFX_AREA]))
    else $error("area value changed");

endmodule

// ==== tb/lcdrce_mem_model.sv ====
`timescale 1ns/1ps
module lcdrce_mem_model
  import lcdrce_pkg::*;
(
  input  wire logic           clk_i,
  input  wire lcdrce_mem_type mem_i,
  output logic [7:0]          rdata_o
);
  logic [7:0] mem [65536];

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0];
    end
    rdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////
  // read data valid one cycle after the strobe only
  // off-strobe cycles invert the last output, so stale data shows only every other cycle
  always @(posedge clk_i) begin
    if (mem_i.we) begin
      mem[mem_i.addr] <= mem_i.wdata;
    end
    rdata_o <= mem_i.re ? mem[mem_i.addr] : ~rdata_o;
  end
endmodule

// ==== tb/test_lcd_display_ram_command_engine.sv ====
`timescale 1ns/1ps
module test_lcd_display_ram_command_engine
  import lcdrce_pkg::*;
;
  logic            clk_i = 1'b0;
  logic            reset_n_i = 1'b0;
  lcdrce_host_type host_i = '0;
  logic [7:0]      host_data_o;
  logic [1:0]      pins = 2'b00;
  logic [7:0]      rdata;
  lcdrce_mem_type  mem_o;
  logic [7:0]      text_pix = 8'h00;
  logic [3:0]      scan = 4'h0;
  logic [15:0]     txt_a, gfx_a;
  logic [6:0]      cols;
  logic            txt_en, gfx_en, attr_f, cur_en, cur_bl, cg_ext, peek_err;
  logic [3:0]      cur_lines;
  logic [7:0]      attr_byte = 8'h00;
  logic [7:0]      cg_code = 8'h00;
  lcdrce_attr_type attr;
  int              error_cnt = 0;
  int              total_checks = 0;
  int              cyc = 0;
  logic [7:0]      v;
  logic [23:0]     rows [8] = '{24'h000000, 24'h0527f0, 24'h031801, 24'h084ff1,
                                24'h0d6400, 24'h0b5c31, 24'hf527e0, 24'ha00811};

  always #5 clk_i = ~clk_i;

  lcdrce_engine #(.COLS_LL(7'h08), .LCD_ROWS(16'h0004)) i_lcdrce_engine (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .host_i(host_i), .host_data_o(host_data_o),
    .column_cfg_pin_a_i(pins[1]), .column_cfg_pin_b_i(pins[0]), .mem_rdata_i(rdata),
    .mem_o(mem_o), .text_pix_i(text_pix), .scan_frame_i(scan[3]), .scan_row_i(scan[2]),
    .scan_txt_row_i(scan[1]), .scan_col_i(scan[0]), .scan_txt_addr_o(txt_a),
    .scan_gfx_addr_o(gfx_a), .hw_column_count_o(cols), .txt_en_o(txt_en), .gfx_en_o(gfx_en),
    .attr_fetch_o(attr_f), .cursor_en_o(cur_en), .cursor_blink_o(cur_bl),
    .cursor_lines_o(cur_lines), .attr_byte_i(attr_byte), .attr_o(attr), .cg_code_i(cg_code),
    .cg_ext_o(cg_ext), .peek_error_flag_o(peek_err));

  lcdrce_mem_model i_lcdrce_mem_model (.clk_i(clk_i), .mem_i(mem_o), .rdata_o(rdata));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic hw(input logic cd, input logic [7:0] d);
    @(posedge clk_i);
    host_i <= '{wr: 1'b1, rd: 1'b0, cd: cd, data: d};
    @(posedge clk_i);
    host_i.wr <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // parameter bytes first, command last, low byte leading
  task automatic p16(input logic [15:0] p, input logic [7:0] c);
    hw(1'b0, p[7:0]);
    hw(1'b0, p[15:8]);
    hw(1'b1, c);
  endtask

  task automatic hr(input logic cd, output logic [7:0] d);
    @(posedge clk_i);
    host_i.rd <= 1'b1;
    host_i.cd <= cd;
    @(posedge clk_i);
    host_i.rd <= 1'b0;
    #1 d = host_data_o;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk_i);
    scan <= m;
    @(posedge clk_i);
    scan <= 4'h0;
    #1;
  endtask

  task automatic tend(input string n);
    $display("test %s done", n);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // a hang ends the run well past the expected length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      test_done;
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("cursor_lines", cur_lines, 16'h1);
    chk("peek_err", peek_err, 16'h0);
    chk("mem_addr", mem_o.addr, ZERO16);
    chk("mem_ctl", 16'({mem_o.wdata, mem_o.we, mem_o.re}), 16'h0000);
    chk("cols_ll", cols, 16'h08);
    tend("reset");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      attr_byte <= rows[k][23:16];
      cg_code <= rows[k][11:4];
      @(posedge clk_i);
      #1;
      chk("attr", attr, rows[k][14:12]);
      chk("cg_ext", cg_ext, rows[k][0]);
    end
    tend("table");
    @(posedge clk_i);
    pins <= 2'b11;
    repeat (2) @(posedge clk_i);
    #1 chk("cols_hh", cols, COLS_HH);
    p16(16'h0014, CMD_CTRL | 8'h01);
    p16(16'h0100, CMD_CTRL | 8'h02);
    p16(16'h0020, CMD_CTRL | 8'h03);
    pulse(4'h8);
    chk("gfx_home", gfx_a, 16'h0100);
    chk("txt_home", txt_a, 16'h0000);
    pulse(4'h4);
    chk("gfx_row", gfx_a, 16'h0120);
    pulse(4'h1);
    chk("gfx_col", gfx_a, 16'h0121);
    pulse(4'h2);
    chk("txt_row", txt_a, 16'h0014);
    pulse(4'h4);
    chk("gfx_row2", gfx_a, 16'h0140);
    tend("scan");
    hw(1'b1, CMD_MODE | 8'h04);
    hw(1'b1, CMD_DISP | 8'h0f);
    chk("gfx_off", gfx_en, 16'h0);
    chk("txt_on", txt_en, 16'h1);
    chk("attr_fetch", attr_f, 16'h1);
    chk("cur_en", {cur_en, cur_bl}, 16'h3);
    hw(1'b1, CMD_MODE);
    chk("gfx_on", gfx_en, 16'h1);
    for (int k = 0; k < 8; k++) begin
      hw(1'b1, CMD_CUR | k[7:0]);
      chk("cur_lines", cur_lines, k[15:0] + 16'h1);
    end
    tend("mode");
    p16(16'h0010, CMD_ADP);
    hw(1'b0, 8'h5a);
    hw(1'b1, CMD_DRW);
    hw(1'b0, 8'ha5);
    hw(1'b1, CMD_DRW | 8'h02);
    hw(1'b0, 8'h3c);
    hw(1'b1, CMD_DRW | 8'h04);
    chk("wr_10", i_lcdrce_mem_model.mem[16'h0010], 16'h3c);
    chk("wr_11", i_lcdrce_mem_model.mem[16'h0011], 16'ha5);
    for (int k = 0; k < 4; k++) begin
      hw(1'b1, 8'hc1 | {5'h0, 2'(32'h0212 >> (4 * (3 - k))), 1'b0});
      hr(1'b0, v);
      chk("rd", v, (k == 1 || k == 2) ? 16'ha5 : 16'h3c);
    end
    tend("single");
    p16(16'h0040, CMD_ADP);
    hw(1'b1, CMD_AUTO_WR);
    hr(1'b1, v);
    chk("aw_stat", v[3], 16'h1);
    for (int k = 1; k < 4; k++) begin
      hw(1'b0, 8'h11 * k[7:0]);
    end
    hw(1'b1, CMD_CUR);
    chk("auto_refuse", cur_lines, 16'h8);
    hw(1'b1, CMD_AUTO_RST);
    for (int k = 0; k < 3; k++) begin
      chk("aw_mem", i_lcdrce_mem_model.mem[16'h0040 + k[15:0]], 16'(16'h11 * (k + 1)));
    end
    p16(16'h0040, CMD_ADP);
    hw(1'b1, CMD_AUTO_RD);
    hr(1'b1, v);
    chk("ar_stat", v[2], 16'h1);
    for (int k = 1; k < 4; k++) begin
      hr(1'b0, v);
      chk("ar_data", v, 16'(16'h11 * k));
    end
    hw(1'b1, CMD_AUTO_RST);
    tend("auto");
    hw(1'b1, CMD_DISP | 8'h0c);
    p16(16'h0180, CMD_ADP);
    hw(1'b1, CMD_PEEK);
    chk("peek_out", peek_err, 16'h1);
    hr(1'b1, v);
    chk("peek_stat", v[6], 16'h1);
    p16(16'h0105, CMD_ADP);
    chk("peek_clr", peek_err, 16'h0);
    @(posedge clk_i);
    text_pix <= 8'hf4;
    hw(1'b1, CMD_PEEK);
    hr(1'b0, v);
    chk("peek_data", v, 16'hf5);
    hw(1'b1, CMD_MODE | 8'h01);
    hw(1'b1, CMD_PEEK);
    hr(1'b0, v);
    chk("peek_exor", v, 16'hf1);
    hw(1'b1, CMD_MODE | 8'h0b);
    hw(1'b1, CMD_PEEK);
    hr(1'b0, v);
    chk("peek_and", v, 16'h04);
    cg_code <= 8'h00;
    hw(1'b1, CMD_MODE | 8'h08);
    chk("cg_ext_mode", cg_ext, 16'h1);
    tend("peek");
    @(posedge clk_i);
    text_pix <= 8'h80;
    p16(16'h0100, CMD_ADP);
    hw(1'b1, CMD_COPY);
    repeat (110) @(posedge clk_i);
    chk("copy_first", i_lcdrce_mem_model.mem[16'h0100], 16'h80);
    chk("copy_last", i_lcdrce_mem_model.mem[16'h011f], 16'h9f);
    chk("copy_past", i_lcdrce_mem_model.mem[16'h0120], 16'h20);
    tend("copy");
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("rst_lines", cur_lines, 16'h1);
    chk("rst_gfx", gfx_a, 16'h0000);
    tend("reset2");
    test_done;
  end
endmodule
